// ===== design/cgcfg_pkg.sv
// Package with register offsets, field positions, reset values and decode constants of the clock generator.
package cgcfg_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
   localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
   localparam logic [2:0] ADDR_STAT_ONE = 3'h2;
   localparam logic [2:0] ADDR_STAT_TWO = 3'h3;
   localparam logic [2:0] ADDR_FILT_HI = 3'h4;
   localparam logic [2:0] ADDR_FILT_LO = 3'h5;
   localparam logic [2:0] ADDR_TRIM = 3'h6;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int C1_HIGH_GAIN = 7;
   localparam int C1_RANGE = 6;
   localparam int C1_REF_SEL = 5;
   localparam int C1_SRC_HI = 4;
   localparam int C1_SRC_LO = 3;
   localparam int C1_OSC_KEEP = 2;
   localparam int C1_LOSS_DIS = 1;
   localparam int C2_LOCK_RST = 7;
   localparam int C2_MUL_HI = 6;
   localparam int C2_MUL_LO = 4;
   localparam int C2_CLK_RST = 3;
   localparam int C2_DIV_HI = 2;
   localparam int S1_IRQ_FLAG = 0;
   localparam int S1_LOCK = 3;
   localparam int S1_LOCK_LOSS = 2;
   localparam int S1_CLK_LOSS = 1;
   localparam int S2_OSC_STABLE = 0;
   // ----------------------------------------
   // Reset values and decode constants
   // ----------------------------------------
   // Source field clear, so the generator leaves every reset in self-clocked mode.
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] CTRL_TWO_RST = 8'h18;
   localparam logic [11:0] FILT_RST = 12'h000;
   localparam logic [7:0] TRIM_RST = 8'h80;
   localparam logic [1:0] SRC_LOCK_INT = 2'h1;
   localparam logic [1:0] SRC_LOCK_EXT = 2'h3;
   localparam logic [6:0] PRESCALE_LOW = 7'h40;
   localparam logic [6:0] PRESCALE_HIGH = 7'h01;
   localparam logic [4:0] MUL_BASE = 5'h04;
   localparam logic [2:0] INT_REF_DIV = 3'h7;
   localparam logic [3:0] FILT_UNUSED = 4'h0;
   localparam logic [15:0] CYCLES_PER_MS = 16'h4E20;
   typedef enum logic [1:0]
   {
      CG_SELF = 2'b00,
      CG_BYPASS = 2'b01,
      CG_LOCK_INT = 2'b10,
      CG_LOCK_EXT = 2'b11
   } cgcfg_mode_t;
endpackage

// ===== design/cgcfg_top.sv
// Clock generator configuration registers, mode decode and loss handling.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
// Notes on behaviour
// - After reset the generator sits in self-clocked mode, about 8 MHz output.
// - Locked-external output equals external reference times P times N over R.
// - Locked-internal output equals internal reference over 7, times 64, N, over R.
// - Control one bit 6 picks range: zero gives prescale 64, one gives 1 in locked-external mode only (other modes keep 64).
// - Source field bits 4:3: 11 is locked-external, 01 is locked-internal.
// - Bit 5 requests crystal oscillator; refSelect ignores it in locked-internal mode, clock-loss detection still uses it.
// - Control one bit 7 zero selects the standard low-power oscillator.
// - Control one bit 0 is unimplemented and always reads zero.
// - Control two bit 7 zero makes loss of lock an interrupt, not reset.
// - Control two bit 3 zero makes loss of clock an interrupt, not reset.
// - Multiply field bits 6:4 sets N; code 000 is 4, 011 is 10.
// - Divider field bits 2:0 sets R; code 000 is one, 001 is two.
// - Status one is read-only; a write clears the pending interrupt flag.
// - Filter value bits 11:0 adjusted by the loop; bits 15:12 read zero.
// - Eight-bit trim tunes internal reference; no effect with external crystal.
// - Multiply codes give N 4 to 18 step two; divider gives R 1 to 128.
// - High-gain select takes only the first write after any reset.
module cgcfg_top
   import cgcfg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [2:0] busAddr,
   input wire logic [7:0] busWrData,
   input wire logic busWrStb,
   input wire logic busRdStb,
   output logic [7:0] busRdData,
   input wire logic loopLocked,
   input wire logic refClockLost,
   input wire logic oscStable,
   input wire logic filterLoad,
   input wire logic [11:0] filterLoopValue,
   output logic [1:0] genMode,
   output logic rangeHigh,
   output logic [6:0] prescaleP,
   output logic [4:0] multiplyN,
   output logic [7:0] outputDividerR,
   output logic refSelect,
   output logic highGainSelect,
   output logic oscStopKeep,
   output logic lossDetectDisable,
   output logic [7:0] internalRefTrim,
   output logic [11:0] loopFilterValue,
   output logic genIrqReq,
   output logic genResetReq
);
   logic [7:0] ctrlOne_reg;
   logic [7:0] ctrlTwo_reg;
   logic hgWritten_reg;
   logic [11:0] filt_reg;
   logic [7:0] trim_reg;
   logic irqFlag_reg;
   logic lockLoss_reg;
   logic clkLoss_reg;
   logic lockPrev_reg;
   logic [7:0] rdData_next;
   logic [1:0] srcSel;
   logic lockLossEvt;
   logic clkLossEvt;
   logic wrOne;
   logic wrTwo;
   cgcfg_mode_t mode_next;

   assign srcSel = ctrlOne_reg[C1_SRC_HI:C1_SRC_LO];
   assign wrOne = busWrStb && (busAddr == ADDR_CTRL_ONE);
   assign wrTwo = busWrStb && (busAddr == ADDR_CTRL_TWO);
   assign lockLossEvt = lockPrev_reg && !loopLocked && srcSel[0];
   assign clkLossEvt = refClockLost && !ctrlOne_reg[C1_LOSS_DIS] && ctrlOne_reg[C1_REF_SEL];

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrlOne_reg <= CTRL_ONE_RST;
         hgWritten_reg <= 1'b0;
      end
      else if (wrOne)
      begin
         ctrlOne_reg[6:1] <= busWrData[6:1];
         ctrlOne_reg[0] <= 1'b0;
         if (!hgWritten_reg)
         begin
            ctrlOne_reg[C1_HIGH_GAIN] <= busWrData[C1_HIGH_GAIN];
            hgWritten_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         ctrlTwo_reg <= CTRL_TWO_RST;
      else if (wrTwo)
         ctrlTwo_reg <= busWrData;
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         trim_reg <= TRIM_RST;
      else if (busWrStb && busAddr == ADDR_TRIM)
         trim_reg <= busWrData;
   end

   // The loop load wins while locked (source bit 3 set); software writes land in any mode when no load is pending.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         filt_reg <= FILT_RST;
      else if (filterLoad && srcSel[0])
         filt_reg <= filterLoopValue;
      else if (busWrStb && busAddr == ADDR_FILT_HI)
         filt_reg[11:8] <= busWrData[3:0];
      else if (busWrStb && busAddr == ADDR_FILT_LO)
         filt_reg[7:0] <= busWrData;
   end

   // ----------------------------------------
   // Loss events and interrupt flag
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         lockPrev_reg <= 1'b0;
      else
         lockPrev_reg <= loopLocked;
   end

   // A new event in the clearing cycle keeps its loss flag set, and the interrupt flag too when that event is routed to the interrupt.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         irqFlag_reg <= 1'b0;
         lockLoss_reg <= 1'b0;
         clkLoss_reg <= 1'b0;
      end
      else
      begin
         if (lockLossEvt)
            lockLoss_reg <= 1'b1;
         else if (busWrStb && busAddr == ADDR_STAT_ONE)
            lockLoss_reg <= 1'b0;
         if (clkLossEvt)
            clkLoss_reg <= 1'b1;
         else if (busWrStb && busAddr == ADDR_STAT_ONE)
            clkLoss_reg <= 1'b0;
         if ((lockLossEvt && !ctrlTwo_reg[C2_LOCK_RST]) || (clkLossEvt && !ctrlTwo_reg[C2_CLK_RST]))
            irqFlag_reg <= 1'b1;
         else if (busWrStb && busAddr == ADDR_STAT_ONE)
            irqFlag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         genIrqReq <= 1'b0;
         genResetReq <= 1'b0;
      end
      else
      begin
         genIrqReq <= irqFlag_reg;
         genResetReq <= (lockLossEvt && ctrlTwo_reg[C2_LOCK_RST]) || (clkLossEvt && ctrlTwo_reg[C2_CLK_RST]);
      end
   end

   // ----------------------------------------
   // Mode and factor decode
   // ----------------------------------------
   always_comb
   begin
      case (srcSel)
         SRC_LOCK_EXT: mode_next = CG_LOCK_EXT;
         SRC_LOCK_INT: mode_next = CG_LOCK_INT;
         2'h2: mode_next = CG_BYPASS;
         default: mode_next = CG_SELF;
      endcase
   end

   // Locked-internal mode always uses the 64 prescale and the internal reference over seven.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         genMode <= CG_SELF;
         rangeHigh <= 1'b0;
         prescaleP <= PRESCALE_LOW;
         multiplyN <= MUL_BASE;
         outputDividerR <= 8'h01;
         refSelect <= 1'b0;
         highGainSelect <= 1'b0;
         oscStopKeep <= 1'b0;
         lossDetectDisable <= 1'b0;
         internalRefTrim <= TRIM_RST;
         loopFilterValue <= FILT_RST;
      end
      else
      begin
         genMode <= mode_next;
         rangeHigh <= ctrlOne_reg[C1_RANGE];
         if (mode_next == CG_LOCK_EXT && ctrlOne_reg[C1_RANGE])
            prescaleP <= PRESCALE_HIGH;
         else
            prescaleP <= PRESCALE_LOW;
         multiplyN <= MUL_BASE + {1'b0, ctrlTwo_reg[C2_MUL_HI:C2_MUL_LO], 1'b0};
         outputDividerR <= 8'h01 << ctrlTwo_reg[C2_DIV_HI:0];
         refSelect <= (mode_next == CG_LOCK_INT) ? 1'b0 : ctrlOne_reg[C1_REF_SEL];
         highGainSelect <= ctrlOne_reg[C1_HIGH_GAIN];
         oscStopKeep <= ctrlOne_reg[C1_OSC_KEEP];
         lossDetectDisable <= ctrlOne_reg[C1_LOSS_DIS];
         internalRefTrim <= trim_reg;
         loopFilterValue <= filt_reg;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb
   begin
      rdData_next = 8'h00;
      case (busAddr)
         ADDR_CTRL_ONE: rdData_next = {ctrlOne_reg[7:1], 1'b0};
         ADDR_CTRL_TWO: rdData_next = ctrlTwo_reg;
         ADDR_STAT_ONE: rdData_next = {4'h0, loopLocked, lockLoss_reg, clkLoss_reg, irqFlag_reg};
         ADDR_STAT_TWO: rdData_next = {7'h00, oscStable};
         ADDR_FILT_HI: rdData_next = {FILT_UNUSED, filt_reg[11:8]};
         ADDR_FILT_LO: rdData_next = filt_reg[7:0];
         ADDR_TRIM: rdData_next = trim_reg;
         default: rdData_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         busRdData <= 8'h00;
      else if (busRdStb)
         busRdData <= rdData_next;
      else
         busRdData <= 8'h00;
   end
endmodule

// ===== tb/cgcfg_top_assertions.sv
// Port checker of the clock generator configuration block.
`timescale 1ns/10ps
module cgcfg_checker
   import cgcfg_pkg::*;
(
   input logic clk_sys,
   input logic rst_b,
   input logic [2:0] busAddr,
   input logic [7:0] busWrData,
   input logic busWrStb,
   input logic busRdStb,
   input logic [7:0] busRdData,
   input logic [1:0] genMode,
   input logic rangeHigh,
   input logic [6:0] prescaleP,
   input logic [4:0] multiplyN,
   input logic [7:0] outputDividerR,
   input logic highGainSelect
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic hgDone_reg;
   sequence c1Wr; busWrStb && busAddr == ADDR_CTRL_ONE; endsequence
   sequence c2Wr; busWrStb && busAddr == ADDR_CTRL_TWO; endsequence
   // Remembers the first control-one write, after which the gain bit is frozen.
   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
         hgDone_reg <= 1'b0;
      else if (busWrStb && busAddr == ADDR_CTRL_ONE)
         hgDone_reg <= 1'b1;
   AST_RD_IDLE: assert property (!$past(busRdStb) |-> busRdData == 8'h00)
      else $error("read data not idle");
   AST_C1_BIT0: assert property ($past(busRdStb) && $past(busAddr) == ADDR_CTRL_ONE |-> !busRdData[0])
      else $error("control one bit 0 read high");
   // Only the locked-external loop honours the high range; the internal loop keeps the 64 prescale.
   AST_PRESCALE: assert property ((rangeHigh && genMode == CG_LOCK_EXT) ? prescaleP == PRESCALE_HIGH
      : prescaleP == PRESCALE_LOW)
      else $error("prescale does not match range and mode");
   AST_N_RANGE: assert property (!multiplyN[0] && multiplyN >= 5'h04 && multiplyN <= 5'h12)
      else $error("multiply factor out of range");
   AST_R_POW2: assert property ($onehot(outputDividerR))
      else $error("divider not a power of two");
   AST_MUL_WR: assert property (c2Wr |-> ##2 multiplyN == MUL_BASE + {$past(busWrData[6:4], 2), 1'b0})
      else $error("multiply factor not taken from write");
   AST_MODE_WR: assert property (c1Wr |-> ##2 genMode == {$past(busWrData[3], 2), $past(busWrData[4], 2)}
      && rangeHigh == $past(busWrData[6], 2))
      else $error("mode or range not taken from write");
   AST_HG_ONCE: assert property (hgDone_reg ##0 c1Wr |-> ##2 $stable(highGainSelect))
      else $error("gain select changed after first write");
endmodule
bind cgcfg_top cgcfg_checker cgcfg_checker_inst (.clk_sys, .rst_b, .busAddr, .busWrData, .busWrStb, .busRdStb,
   .busRdData, .genMode, .rangeHigh, .prescaleP, .multiplyN, .outputDividerR, .highGainSelect);

// ===== tb/test_cgcfg_top.sv
// Self-checking bench of the clock generator configuration block.
`timescale 1ns/10ps
module test_cgcfg_top
   import cgcfg_pkg::*;
;
   logic clk_sys = 1'b0, rst_b = 1'b0, busWrStb = 1'b0, busRdStb = 1'b0, seen;
   logic [2:0] busAddr = 3'h0;
   logic [7:0] busWrData = 8'h00, busRdData, rdVal, outputDividerR, internalRefTrim;
   logic loopLocked = 1'b1, refClockLost = 1'b0, oscStable = 1'b0, filterLoad = 1'b0;
   logic [11:0] filterLoopValue = 12'hABC, loopFilterValue;
   logic [1:0] genMode;
   logic rangeHigh, refSelect, highGainSelect, oscStopKeep, lossDetectDisable, genIrqReq, genResetReq;
   logic [6:0] prescaleP;
   logic [4:0] multiplyN;
   int fails = 0, n_checks = 0, cyc = 0;
   // Rows: written value, read-back, {0, reference, keep, loss-disable, 00, mode}, prescale.
   logic [31:0] c1Rows [5] = '{32'h00800040, 32'h16963140, 32'h28A80240, 32'h78F84301, 32'hB9B84340};
   // Rows: written value, multiply factor, divider.
   logic [23:0] c2Rows [8] = '{24'h000401, 24'h110602, 24'h220804, 24'h330A08, 24'h440C10, 24'h550E20,
      24'h661040, 24'h771280};
   cgcfg_top cgcfg_top_inst (.clk_sys, .rst_b, .busAddr, .busWrData, .busWrStb, .busRdStb, .busRdData,
      .loopLocked, .refClockLost, .oscStable, .filterLoad, .filterLoopValue, .genMode, .rangeHigh, .prescaleP,
      .multiplyN, .outputDividerR, .refSelect, .highGainSelect, .oscStopKeep, .lossDetectDisable,
      .internalRefTrim, .loopFilterValue, .genIrqReq, .genResetReq);
   always #25 clk_sys = ~clk_sys;
   task automatic results();
      if (fails == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         fails++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      busAddr <= a;
      busWrData <= d;
      busWrStb <= 1'b1;
      @(posedge clk_sys);
      busWrStb <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge clk_sys);
      busAddr <= a;
      busRdStb <= 1'b1;
      @(posedge clk_sys);
      busRdStb <= 1'b0;
      @(posedge clk_sys);
      rdVal = busRdData;
   endtask
   initial
   begin
      repeat (20) @(posedge clk_sys);
      chk(genMode, CG_SELF);
      rst_b <= 1'b1;
      rd(ADDR_CTRL_ONE);
      chk(rdVal, CTRL_ONE_RST);
      rd(3'h7);
      chk(rdVal, 8'h00);
      chk(genMode, CG_SELF);
      rd(ADDR_STAT_TWO);
      chk(rdVal, 8'h00);
      oscStable <= 1'b1;
      // Software waits for the stable flag, with a bound so a stuck flag cannot hang the run.
      for (int k = 0; k < 4 && !rdVal[S2_OSC_STABLE]; k++)
         rd(ADDR_STAT_TWO);
      chk(rdVal, 8'h01);
      wr(ADDR_CTRL_ONE, 8'hB8);
      for (int i = 0; i < 5; i++)
      begin
         wr(ADDR_CTRL_ONE, c1Rows[i][31:24]);
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk(genMode, c1Rows[i][9:8]);
         chk(prescaleP, c1Rows[i][6:0]);
         chk(highGainSelect, 1'b1);
         chk({refSelect, oscStopKeep, lossDetectDisable}, c1Rows[i][14:12]);
         rd(ADDR_CTRL_ONE);
         chk(rdVal, c1Rows[i][23:16]);
      end
      for (int i = 0; i < 8; i++)
      begin
         wr(ADDR_CTRL_TWO, c2Rows[i][23:16]);
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk(multiplyN, c2Rows[i][15:8]);
         chk(outputDividerR, c2Rows[i][7:0]);
         rd(ADDR_CTRL_TWO);
         chk(rdVal, c2Rows[i][23:16]);
      end
      @(posedge clk_sys);
      filterLoad <= 1'b1;
      @(posedge clk_sys);
      filterLoad <= 1'b0;
      rd(ADDR_FILT_HI);
      chk(rdVal, 8'h0A);
      rd(ADDR_FILT_LO);
      chk(rdVal, 8'hBC);
      chk(loopFilterValue, 12'hABC);
      // Trim with the divider doubled, then restore it, so the output never overshoots.
      wr(ADDR_CTRL_TWO, 8'h01);
      wr(ADDR_TRIM, 8'h5A);
      chk(outputDividerR, 8'h02);
      rd(ADDR_TRIM);
      chk(rdVal, 8'h5A);
      chk(internalRefTrim, 8'h5A);
      wr(ADDR_CTRL_TWO, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk(outputDividerR, 8'h01);
      @(posedge clk_sys);
      loopLocked <= 1'b0;
      seen = 1'b0;
      repeat (4) @(negedge clk_sys) seen = seen | genIrqReq;
      chk({seen, genResetReq}, 2'b10);
      rd(ADDR_STAT_ONE);
      chk(rdVal, 8'h05);
      wr(ADDR_STAT_ONE, 8'hFF);
      rd(ADDR_STAT_ONE);
      chk(rdVal, 8'h00);
      chk(genIrqReq, 1'b0);
      wr(ADDR_CTRL_TWO, 8'h80);
      loopLocked <= 1'b1;
      repeat (3) @(posedge clk_sys);
      loopLocked <= 1'b0;
      seen = 1'b0;
      repeat (4) @(negedge clk_sys) seen = seen | genResetReq;
      chk(seen, 1'b1);
      @(posedge clk_sys);
      refClockLost <= 1'b1;
      seen = 1'b0;
      repeat (4) @(negedge clk_sys) seen = seen | genIrqReq;
      chk(seen, 1'b1);
      // A second reset must reopen the one-time gain bit.
      @(posedge clk_sys);
      refClockLost <= 1'b0;
      rst_b <= 1'b0;
      @(negedge clk_sys);
      chk({genMode, highGainSelect}, 3'b000);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(genMode, CG_SELF);
      wr(ADDR_CTRL_ONE, 8'h80);
      rd(ADDR_CTRL_ONE);
      chk(rdVal, 8'h80);
      results();
   end
endmodule
